// ==== include/pfm_defines.vh ====
`ifndef PFM_DEFINES_VH
`define PFM_DEFINES_VH

// Object indices of the monitor.
`define PFM_IDX_ACTIVE_MODE    16'h6061
`define PFM_IDX_DEMAND_POS     16'h6062
`define PFM_IDX_RAW_ENC_POS    16'h6063
`define PFM_IDX_ACTUAL_POS     16'h6064
`define PFM_IDX_FERR_WINDOW    16'h6065
`define PFM_IDX_FERR_TIMEOUT   16'h6066
`define PFM_IDX_TGT_WINDOW     16'h6067
`define PFM_IDX_TGT_TIME       16'h6068
`define PFM_IDX_VEL_DEMAND     16'h606B

// Reset values.
`define PFM_RST_ACTIVE_MODE    8'h00
`define PFM_RST_POS            32'h00000000
`define PFM_RST_FERR_WINDOW    32'h00000100
`define PFM_RST_FERR_TIMEOUT   16'h0064
`define PFM_RST_TGT_WINDOW     32'h0000000A
`define PFM_RST_TGT_TIME       16'h0064

// Window value that switches monitoring off.
`define PFM_WINDOW_OFF         32'hFFFFFFFF

// Drive status word bit positions.
`define PFM_SW_TARGET_REACHED  10
`define PFM_SW_FOLLOWING_ERR   13

// Operating mode codes.
`define PFM_MODE_AUTO_SETUP    8'hFE
`define PFM_MODE_CLOCK_DIR     8'hFF
`define PFM_MODE_NONE          8'h00
`define PFM_MODE_PROFILE_POS   8'h01
`define PFM_MODE_RESERVED      8'h05
`define PFM_MODE_INTERP_POS    8'h07
`define PFM_MODE_MAX           8'h0A

// Timing: one millisecond at a 5 ns clock.
`define PFM_MS_NS              1000000
`define PFM_CLK_PERIOD_NS      5
`define PFM_MS_CYCLES          (`PFM_MS_NS / `PFM_CLK_PERIOD_NS)

// Error history code pushed on a following error.
`define PFM_ERR_CODE_FERR      16'h8611

`endif

// ==== src/pfm_persist_timer.v ====
`timescale 1ns/1ps

module pfm_persist_timer (
  // Clock and reset.
  input  wire        i_ref_clk,
  input  wire        i_nrst,
  // Condition and timing.
  input  wire        i_cond,
  input  wire        i_ms_tick,
  input  wire [15:0] i_limit_ms,
  // Result.
  output wire        o_hit
);

  reg  [16:0] cnt_ff;
  reg  [16:0] nxt_cnt;

  // Counts whole milliseconds while the condition holds; restarts when it drops.
  always @* begin
    nxt_cnt = cnt_ff;
    if (!i_cond) begin
      nxt_cnt = 17'h00000;
    end else if (i_ms_tick && !cnt_ff[16]) begin
      nxt_cnt = cnt_ff + 17'h00001;
    end
  end

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= 17'h00000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Hit only once the condition has lasted longer than the limit.
  assign o_hit = i_cond && (cnt_ff > {1'b0, i_limit_ms});

endmodule

// ==== src/pfm_monitor.v ====
`timescale 1ns/1ps
`include "pfm_defines.vh"

// Function
// - Persistent large following error sets bit 13.
// - All-ones following window disables error monitoring.
// - Following timeout counted in milliseconds, default 100.
// - Following window symmetric about demand, default 256.
// - Configured reaction also logs an error entry.
// - Persistent target proximity sets bit 10.
// - All-ones position window disables target monitoring.
// - Window time used in position modes only.
// - Raw encoder position not zeroed by homing.
// - Raw position invalid when encoder resolution zero.
// - Ramp output published as velocity demand.
// - Read-only signed 8-bit active mode, reset zero.
// - Mode codes -2 to 10, 5 reserved.

module pfm_monitor #(
  parameter MS_CYCLES = `PFM_MS_CYCLES
) (
  // Clock and reset.
  input  wire        i_ref_clk,
  input  wire        i_nrst,
  // Object access from the fieldbus side.
  input  wire [15:0] i_obj_index,
  input  wire        i_obj_rd,
  input  wire        i_obj_wr,
  input  wire [31:0] i_obj_wdata,
  output wire [31:0] o_obj_rdata,
  output wire        o_obj_ack,
  output wire        o_obj_err,
  // Loop values from the controller.
  input  wire [31:0] i_demand_pos,
  input  wire [31:0] i_actual_pos,
  input  wire [31:0] i_raw_enc_pos,
  input  wire [31:0] i_target_pos,
  input  wire [31:0] i_ramp_velocity,
  input  wire [7:0]  i_mode_applied,
  input  wire        i_homing_done,
  // Configuration held elsewhere.
  input  wire [31:0] i_encoder_resolution,
  input  wire [15:0] i_following_error_reaction,
  // Status and error history.
  output wire [15:0] o_drive_status_word,
  output wire        o_raw_pos_valid,
  output wire        o_err_hist_push,
  output wire [15:0] o_err_hist_code
);

  reg  [7:0]  mode_ff;
  reg  [31:0] dem_ofs_ff;
  reg  [31:0] act_ofs_ff;
  reg  [31:0] dem_pos_ff;
  reg  [31:0] act_pos_ff;
  reg  [31:0] raw_pos_ff;
  reg  [31:0] vel_dem_ff;
  reg  [31:0] tgt_pos_ff;
  reg  [31:0] ferr_win_ff;
  reg  [15:0] ferr_tmo_ff;
  reg  [31:0] tgt_win_ff;
  reg  [15:0] tgt_time_ff;
  reg  [31:0] rdata_ff;
  reg         ack_ff;
  reg         err_ff;
  reg         ferr_ff;
  reg         tgt_ff;
  reg         push_ff;
  reg         raw_valid_ff;
  reg  [17:0] ms_cnt_ff;
  reg         ms_tick_ff;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;
  reg  [15:0] tgt_limit;
  reg  [15:0] status_word;
  wire [32:0] ferr_mag;
  wire [32:0] tgt_mag;
  wire        ferr_cond;
  wire        tgt_cond;
  wire        ferr_hit;
  wire        tgt_hit;
  wire        obj_wr_ok;
  wire        obj_access;

  // Checks a code against the mode encoding.
  function mode_valid;
    input [7:0] code;
    begin
      mode_valid = 1'b0;
      if (code == `PFM_MODE_AUTO_SETUP || code == `PFM_MODE_CLOCK_DIR) begin
        mode_valid = 1'b1;
      end else if (!code[7] && code <= `PFM_MODE_MAX && code != `PFM_MODE_RESERVED) begin
        mode_valid = 1'b1;
      end
    end
  endfunction

  // True for the modes that judge target reached with the window time.
  function mode_uses_win_time;
    input [7:0] code;
    begin
      mode_uses_win_time = (code == `PFM_MODE_PROFILE_POS) ||
                           (code == `PFM_MODE_INTERP_POS);
    end
  endfunction

  // Tells whether an index is writable.
  function idx_writable;
    input [15:0] idx;
    begin
      idx_writable = (idx == `PFM_IDX_FERR_WINDOW) || (idx == `PFM_IDX_FERR_TIMEOUT) ||
                     (idx == `PFM_IDX_TGT_WINDOW) || (idx == `PFM_IDX_TGT_TIME);
    end
  endfunction

  // A window of all ones switches its monitor off.
  function window_on;
    input [31:0] win;
    begin
      window_on = (win != `PFM_WINDOW_OFF);
    end
  endfunction

  // Magnitude of a signed position difference, one bit wider so it never wraps.
  function [32:0] pos_distance;
    input [31:0] pos_a;
    input [31:0] pos_b;
    reg   [32:0] diff;
    begin
      diff         = {pos_a[31], pos_a} - {pos_b[31], pos_b};
      pos_distance = diff[32] ? (33'h000000000 - diff) : diff;
    end
  endfunction

  // Millisecond tick from the reference clock.
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ms_cnt_ff  <= 18'h00000;
      ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff == MS_CYCLES[17:0] - 18'h00001) begin
      ms_cnt_ff  <= 18'h00000;
      ms_tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff  <= ms_cnt_ff + 18'h00001;
      ms_tick_ff <= 1'b0;
    end
  end

  // Active mode display follows the applied mode when its code is legal.
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_ff <= `PFM_RST_ACTIVE_MODE;
    end else if (mode_valid(i_mode_applied)) begin
      mode_ff <= i_mode_applied;
    end
  end

  // Homing moves the user frame origin; the raw encoder value keeps its count.
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dem_ofs_ff <= `PFM_RST_POS;
      act_ofs_ff <= `PFM_RST_POS;
    end else if (i_homing_done) begin
      dem_ofs_ff <= i_demand_pos;
      act_ofs_ff <= i_actual_pos;
    end
  end

  // Published process values, sampled every cycle.
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dem_pos_ff   <= `PFM_RST_POS;
      act_pos_ff   <= `PFM_RST_POS;
      raw_pos_ff   <= `PFM_RST_POS;
      vel_dem_ff   <= `PFM_RST_POS;
      tgt_pos_ff   <= `PFM_RST_POS;
      raw_valid_ff <= 1'b0;
    end else begin
      if (i_homing_done) begin
        dem_pos_ff <= `PFM_RST_POS;
        act_pos_ff <= `PFM_RST_POS;
      end else begin
        dem_pos_ff <= i_demand_pos - dem_ofs_ff;
        act_pos_ff <= i_actual_pos - act_ofs_ff;
      end
      raw_pos_ff   <= i_raw_enc_pos;
      vel_dem_ff   <= i_ramp_velocity;
      tgt_pos_ff   <= i_target_pos;
      raw_valid_ff <= (i_encoder_resolution != 32'h00000000);
    end
  end

  // Distances of the actual position from demand and from target.
  assign ferr_mag = pos_distance(act_pos_ff, dem_pos_ff);
  assign tgt_mag  = pos_distance(act_pos_ff, tgt_pos_ff);

  // Window comparisons, evaluated every cycle.
  assign ferr_cond = window_on(ferr_win_ff) &&
                     (ferr_mag > {1'b0, ferr_win_ff});
  assign tgt_cond  = window_on(tgt_win_ff) &&
                     (tgt_mag < {1'b0, tgt_win_ff});

  // Position modes use the window time, others the following timeout.
  always @* begin
    if (mode_uses_win_time(mode_ff)) begin
      tgt_limit = tgt_time_ff;
    end else begin
      tgt_limit = ferr_tmo_ff;
    end
  end

  pfm_persist_timer u_ferr_timer (
    .i_ref_clk  (i_ref_clk),
    .i_nrst     (i_nrst),
    .i_cond     (ferr_cond),
    .i_ms_tick  (ms_tick_ff),
    .i_limit_ms (ferr_tmo_ff),
    .o_hit      (ferr_hit)
  );

  pfm_persist_timer u_tgt_timer (
    .i_ref_clk  (i_ref_clk),
    .i_nrst     (i_nrst),
    .i_cond     (tgt_cond),
    .i_ms_tick  (ms_tick_ff),
    .i_limit_ms (tgt_limit),
    .o_hit      (tgt_hit)
  );

  // Status bits and the error history push on a new following error.
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ferr_ff <= 1'b0;
      tgt_ff  <= 1'b0;
      push_ff <= 1'b0;
    end else begin
      ferr_ff <= ferr_hit;
      tgt_ff  <= tgt_hit;
      push_ff <= ferr_hit && !ferr_ff &&
                 (i_following_error_reaction != 16'h0000);
    end
  end

  // Only the two monitor bits of the status word are driven; the rest read zero.
  always @* begin
    status_word                         = 16'h0000;
    status_word[`PFM_SW_FOLLOWING_ERR]  = ferr_ff;
    status_word[`PFM_SW_TARGET_REACHED] = tgt_ff;
  end

  assign o_drive_status_word = status_word;
  assign o_raw_pos_valid     = raw_valid_ff;
  assign o_err_hist_push     = push_ff;
  assign o_err_hist_code     = `PFM_ERR_CODE_FERR;

  // Writable configuration objects.
  assign obj_wr_ok = i_obj_wr && idx_writable(i_obj_index);

  // Any strobe opens an access; a write wins when both are high.
  assign obj_access = i_obj_rd || i_obj_wr;

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ferr_win_ff <= `PFM_RST_FERR_WINDOW;
      ferr_tmo_ff <= `PFM_RST_FERR_TIMEOUT;
      tgt_win_ff  <= `PFM_RST_TGT_WINDOW;
      tgt_time_ff <= `PFM_RST_TGT_TIME;
    end else if (obj_wr_ok) begin
      case (i_obj_index)
        `PFM_IDX_FERR_WINDOW: begin
          ferr_win_ff <= i_obj_wdata;
        end
        `PFM_IDX_FERR_TIMEOUT: begin
          ferr_tmo_ff <= i_obj_wdata[15:0];
        end
        `PFM_IDX_TGT_WINDOW: begin
          tgt_win_ff <= i_obj_wdata;
        end
        `PFM_IDX_TGT_TIME: begin
          tgt_time_ff <= i_obj_wdata[15:0];
        end
        default: begin
          tgt_time_ff <= tgt_time_ff;
        end
      endcase
    end
  end

  // Read mux; unknown indices and writes to read-only objects are refused.
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err   = 1'b0;
    case (i_obj_index)
      `PFM_IDX_ACTIVE_MODE: begin
        nxt_rdata = {{24{mode_ff[7]}}, mode_ff};
      end
      `PFM_IDX_DEMAND_POS: begin
        nxt_rdata = dem_pos_ff;
      end
      `PFM_IDX_RAW_ENC_POS: begin
        nxt_rdata = raw_pos_ff;
      end
      `PFM_IDX_ACTUAL_POS: begin
        nxt_rdata = act_pos_ff;
      end
      `PFM_IDX_FERR_WINDOW: begin
        nxt_rdata = ferr_win_ff;
      end
      `PFM_IDX_FERR_TIMEOUT: begin
        nxt_rdata = {16'h0000, ferr_tmo_ff};
      end
      `PFM_IDX_TGT_WINDOW: begin
        nxt_rdata = tgt_win_ff;
      end
      `PFM_IDX_TGT_TIME: begin
        nxt_rdata = {16'h0000, tgt_time_ff};
      end
      `PFM_IDX_VEL_DEMAND: begin
        nxt_rdata = vel_dem_ff;
      end
      default: begin
        nxt_err = 1'b1;
      end
    endcase
    if (i_obj_wr && !idx_writable(i_obj_index)) begin
      nxt_err = 1'b1;
    end
    if (i_obj_wr || nxt_err) begin
      nxt_rdata = 32'h00000000;
    end
  end

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= 32'h00000000;
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      ack_ff   <= obj_access;
      err_ff   <= obj_access && nxt_err;
      if (obj_access) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign o_obj_rdata = rdata_ff;
  assign o_obj_ack   = ack_ff;
  assign o_obj_err   = err_ff;

endmodule

// ==== test/pfm_motor_model.sv ====
`timescale 1ns/1ps

module pfm_motor_model (
  // Clock.
  input  wire logic        i_ref_clk,
  // Motion commands from the bench.
  input  wire logic [31:0] i_rate,
  input  wire logic [31:0] i_dev,
  // Loop values seen by the monitor.
  output logic      [31:0] o_demand,
  output logic      [31:0] o_actual,
  output logic      [31:0] o_raw,
  output logic      [31:0] o_velocity
);
  logic [31:0] demand_ff = 32'h0;

  // The ramp integrates the rate into the demand position.
  always @(posedge i_ref_clk) begin
    demand_ff <= demand_ff + i_rate;
  end

  assign o_demand   = demand_ff;
  assign o_actual   = demand_ff + i_dev;
  // The encoder counts four increments per user unit.
  assign o_raw      = {o_actual[29:0], 2'b00};
  assign o_velocity = i_rate;
endmodule

// ==== test/pfm_checker_assertions.sv ====
`timescale 1ns/1ps

module pfm_checker #(
  parameter MS_CYCLES = 200000
) (
  // Clock and reset.
  input wire        i_ref_clk,
  input wire        i_nrst,
  // Object port.
  input wire [15:0] i_obj_index,
  input wire        i_obj_rd,
  input wire        i_obj_wr,
  input wire [31:0] o_obj_rdata,
  input wire        o_obj_ack,
  input wire        o_obj_err,
  // Loop values and status.
  input wire [31:0] i_demand_pos,
  input wire [31:0] i_actual_pos,
  input wire [31:0] i_encoder_resolution,
  input wire [15:0] o_drive_status_word,
  input wire        o_raw_pos_valid,
  input wire        o_err_hist_push
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  int unsigned diff_cnt_ff;

  // Counts cycles of unbroken position difference.
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      diff_cnt_ff <= 32'h0;
    else if (i_actual_pos == i_demand_pos)
      diff_cnt_ff <= 32'h0;
    else if (diff_cnt_ff != 32'hFFFFFFFF)
      diff_cnt_ff <= diff_cnt_ff + 32'h1;
  end

  a_ack_after_strobe:
    assert property ((i_obj_rd || i_obj_wr) |=> o_obj_ack)
    else $error("no ack after access");
  a_err_with_ack:
    assert property (o_obj_err |-> o_obj_ack && o_obj_rdata == 32'h0)
    else $error("refusal without ack or with data");
  a_ro_write_refused:
    assert property (i_obj_wr && i_obj_index inside {16'h6061, 16'h6062, 16'h6063,
      16'h6064, 16'h606B} |=> o_obj_err)
    else $error("write to read-only object taken");
  a_raw_valid_lag:
    assert property (1'b1 |=> o_raw_pos_valid == ($past(i_encoder_resolution) != 32'h0))
    else $error("raw valid flag wrong");
  a_push_on_rise:
    assert property (o_err_hist_push |-> $rose(o_drive_status_word[13]))
    else $error("history push without new error");
  a_spare_bits_zero:
    assert property ((o_drive_status_word & 16'hDBFF) == 16'h0)
    else $error("unused status bit set");
  a_ferr_persist:
    assert property ($rose(o_drive_status_word[13]) |-> diff_cnt_ff > MS_CYCLES)
    else $error("following error set too early");
  a_ferr_drops:
    assert property ((i_actual_pos == i_demand_pos) [*3] |=> !o_drive_status_word[13])
    else $error("following error held without deviation");

  c_ferr_set: cover property ($rose(o_drive_status_word[13]));
  c_tgt_set: cover property ($rose(o_drive_status_word[10]));
  c_refused: cover property (o_obj_err);
endmodule

bind pfm_monitor pfm_checker #(.MS_CYCLES(MS_CYCLES)) pfm_checker_inst (
  .i_ref_clk, .i_nrst, .i_obj_index, .i_obj_rd, .i_obj_wr, .o_obj_rdata, .o_obj_ack,
  .o_obj_err, .i_demand_pos, .i_actual_pos, .i_encoder_resolution, .o_drive_status_word,
  .o_raw_pos_valid, .o_err_hist_push);

// ==== test/pfm_monitor_test.sv ====
`timescale 1ns/1ps

module pfm_monitor_test;
  localparam int MS = 20;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic               rd = 1'b0;
  logic               wr = 1'b0;
  logic               hom = 1'b0;
  logic        [15:0] idx = 16'h0;
  logic        [31:0] wdata = 32'h0;
  logic        [31:0] rate = 32'h0;
  logic        [31:0] dev = 32'h0;
  logic        [31:0] hofs = 32'h0;
  logic        [31:0] res = 32'h1;
  logic        [15:0] react = 16'h1;
  logic        [7:0]  mode = 8'h0;
  logic        [31:0] dem, act, raw, vel, rdata, v;
  logic        [15:0] sw, code;
  logic               ack, err, rvalid, push;
  logic signed [31:0] em;
  int                 errors = 0;
  int                 checks_done = 0;
  int                 pushes = 0;
  int                 p0;
  logic        [15:0] ridx [9] = '{16'h6061, 16'h6062, 16'h6063, 16'h6064, 16'h6065,
                                   16'h6066, 16'h6067, 16'h6068, 16'h606B};
  logic        [31:0] rval [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h64, 32'hA,
                                   32'h64, 32'h0};

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (push === 1'b1)
      pushes <= pushes + 1;
  end

  pfm_motor_model pfm_motor_model_inst (
    .i_ref_clk(clk), .i_rate(rate), .i_dev(dev),
    .o_demand(dem), .o_actual(act), .o_raw(raw), .o_velocity(vel));

  pfm_monitor #(.MS_CYCLES(MS)) pfm_monitor_inst (
    .i_ref_clk(clk), .i_nrst(nrst), .i_obj_index(idx), .i_obj_rd(rd), .i_obj_wr(wr),
    .i_obj_wdata(wdata), .o_obj_rdata(rdata), .o_obj_ack(ack), .o_obj_err(err),
    .i_demand_pos(dem), .i_actual_pos(act), .i_raw_enc_pos(raw), .i_target_pos(dem - hofs),
    .i_ramp_velocity(vel), .i_mode_applied(mode), .i_homing_done(hom),
    .i_encoder_resolution(res), .i_following_error_reaction(react),
    .o_drive_status_word(sw), .o_raw_pos_valid(rvalid), .o_err_hist_push(push),
    .o_err_hist_code(code));

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One strobe cycle; the answer is settled at the following falling edge.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    idx = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic e, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk({ack, err, rdata}, {1'b1, e, x});
  endtask

  task automatic wrc(input logic [15:0] a, input logic [31:0] d, input logic e);
    acc(1'b1, a, d);
    chk({ack, err, rdata}, {1'b1, e, 32'h0});
  endtask

  task automatic ferr(input logic [31:0] d, input logic [31:0] w, input logic e);
    wrc(16'h6065, w, 1'b0);
    p0 = pushes;
    dev = d;
    gap(2 * MS);
    chk(sw[13], 1'b0);
    gap(3 * MS);
    chk(sw[13], e);
    chk(pushes - p0, e && react != 16'h0);
    chk(code, 16'h8611);
    dev = 32'h0;
    gap(3);
    chk(sw[13], 1'b0);
  endtask

  task automatic tgt(input logic [7:0] m, input logic [31:0] w, input logic e);
    wrc(16'h6067, w, 1'b0);
    mode = m;
    dev = 32'h14;
    gap(MS);
    chk(sw[10], 1'b0);
    dev = 32'h5;
    gap(3 * MS);
    chk(sw[10], e);
  endtask

  task automatic results;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // The whole sequence needs about 1000 cycles; this cuts a hang short.
  initial begin
    #60000;
    errors++;
    results;
  end

  initial begin
    v = $urandom(46898);
    gap(12);
    nrst = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(ridx[i], 1'b0, rval[i]);
      v = $urandom;
      if (i < 4 || i == 8) begin
        wrc(ridx[i], v, 1'b1);
      end else begin
        wrc(ridx[i], v, 1'b0);
        rdc(ridx[i], 1'b0, (i == 5 || i == 7) ? {16'h0, v[15:0]} : v);
        wrc(ridx[i], rval[i], 1'b0);
      end
      rdc(ridx[i], 1'b0, rval[i]);
    end
    wrc(16'h6060, v, 1'b1);
    rdc(16'h6069, 1'b1, 32'h0);
    em = 32'h0;
    for (int m = -3; m < 12; m++) begin
      mode = m[7:0];
      if (m > -3 && m < 11 && m != 5)
        em = m;
      gap(1);
      rdc(16'h6061, 1'b0, em);
    end
    rate = $urandom;
    dev = $urandom % 32'h64;
    gap(3);
    rdc(16'h606B, 1'b0, rate);
    rate = 32'h0;
    gap(3);
    rdc(16'h6062, 1'b0, dem);
    rdc(16'h6064, 1'b0, act);
    dev = 32'h0;
    gap(2);
    hom = 1'b1;
    hofs = dem;
    gap(1);
    hom = 1'b0;
    gap(2);
    rdc(16'h6062, 1'b0, 32'h0);
    rdc(16'h6064, 1'b0, 32'h0);
    rdc(16'h6063, 1'b0, raw);
    res = 32'h0;
    gap(2);
    chk(rvalid, 1'b0);
    res = $urandom | 32'h1;
    gap(2);
    chk(rvalid, 1'b1);
    wrc(16'h6066, 32'h2, 1'b0);
    ferr(32'h101 + $urandom % 32'h3E8, 32'h100, 1'b1);
    ferr(32'hFFFFFED4, 32'h100, 1'b1);
    ferr(32'h100, 32'h100, 1'b0);
    ferr(32'h12C, 32'hFFFFFFFF, 1'b0);
    react = 16'h0;
    ferr(32'h101, 32'h100, 1'b1);
    wrc(16'h6066, 32'h5, 1'b0);
    wrc(16'h6068, 32'h1, 1'b0);
    tgt(8'h01, 32'hA, 1'b1);
    tgt(8'h07, 32'hA, 1'b1);
    tgt(8'h03, 32'hA, 1'b0);
    tgt(8'h01, 32'hFFFFFFFF, 1'b0);
    results;
  end
endmodule
